// ==== core/adcsp_pkg.sv ====
// Constants and state types shared by the converter serial readout port.
// Assumes a converter clock domain and a serial clock domain from the host.
//
// Summary of operation
// - Every transfer is framed in whole bytes.
// - Host sends or device returns, one direction.
// - Chip select high resets port, output floats.
// - Enabled idle clock timeout resets serial port.
// - Input bits sampled on serial clock falling.
// - Output bits shifted on rising, MSB first.
// - Continuous mode output mirrors ready until first clock edge.
// - Ready on pin; on status bit outside continuous mode.
// - Ready inactive high after device reset.
// - Gated mode: first read edge clears ready.
// - Gated mode: unread result pulses ready high.
// - Pulsed mode: ready low until next start.
// - Result is 24-bit twos complement, MSB first.
// - Output code saturates, never wraps.
// - Checksum is byte sum plus fixed offset.
// - Checksum appended to conversion results only.
// - Range flag alone replaces result bit zero.
// - Flag and checksum: flag in checksum bit 7.
// - Extra clocking repeats the same result bytes.
// - Read command byte 012h starts result shift.

package adcsp_pkg;

  localparam logic [7:0] CMD_READ_DATA = 8'h12;
  localparam logic [7:0] CMD_CONT_READ = 8'h10;
  localparam logic [7:0] CMD_STOP_READ = 8'h11;
  localparam logic [7:0] CHK_OFFSET = 8'h9b;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [4:0] WORD3_LAST = 5'h17;
  localparam logic [4:0] WORD4_LAST = 5'h1f;
  localparam logic [23:0] SAT_POS = 24'h7fffff;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  localparam int TIMEOUT_CYCLES_DEF = 65536;
  localparam logic READY_RST = 1'b1;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sclk_s;
    logic [1:0] tx_s;
    logic [1:0] shift_s;
    logic [1:0] cont_s;
    logic [1:0] rd_s;
    logic rd_d;
    logic ready_n;
    logic [31:0] word;
    logic len4;
    logic [16:0] to_cnt;
    logic link_rst;
    logic mode_rst;
    logic sdo;
    logic sdo_oe_n;
    logic status_n;
    logic cont;
  } adcsp_core_t;

  typedef struct packed {
    logic [6:0] rx;
    logic [2:0] bit_cnt;
    logic reading;
  } adcsp_rx_t;

  typedef struct packed {
    logic [4:0] idx;
    logic shifted;
    logic tx;
  } adcsp_tx_t;

endpackage

// ==== core/adcsp_link_if.sv ====
// Signals between the converter-clock core and the serial-clock link logic.
// Assumes the word and its length stay still while the host shifts them.
`timescale 1ns/1ps

interface adcsp_link_if;
  logic arst;
  logic mode_rst;
  logic sclk;
  logic sdi;
  logic [31:0] word;
  logic len4;
  logic tx;
  logic shifted;
  logic cont;
  logic rd_tgl;

  modport core
  (
    output arst, mode_rst, sclk, sdi, word, len4,
    input tx, shifted, cont, rd_tgl
  );

  modport link
  (
    input arst, mode_rst, sclk, sdi, word, len4,
    output tx, shifted, cont, rd_tgl
  );
endinterface

// ==== core/adcsp_link.sv ====
// Serial clock side of the readout port: command receive and data shift.
// Assumes arst is high while chip select is high or a timeout fires.
`timescale 1ns/1ps

module adcsp_link
  import adcsp_pkg::*;
(
  adcsp_link_if.link lk
);

  adcsp_rx_t r_reg;
  adcsp_rx_t r_next;
  adcsp_tx_t t_reg;
  adcsp_tx_t t_next;
  logic cont_reg;
  logic cont_next;
  logic rd_tgl_reg;
  logic rd_tgl_next;
  logic [7:0] rx_byte;

  //////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    r_next = r_reg;
    cont_next = cont_reg;
    rx_byte = {r_reg.rx, lk.sdi};
    r_next.rx = rx_byte[6:0];
    r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
    if (r_reg.bit_cnt == BYTE_LAST)
    begin
      // Only the stop command is honoured while continuous mode is on.
      if (rx_byte == CMD_STOP_READ)
        cont_next = 1'b0;
      else if (!cont_reg && rx_byte == CMD_CONT_READ)
        cont_next = 1'b1;
      else if (!cont_reg && rx_byte[7:1] == CMD_READ_DATA[7:1])
        r_next.reading = 1'b1;
    end
  end

  // Bits are taken on the falling edge; counters clear with the frame.
  always_ff @(negedge lk.sclk or posedge lk.arst)
  begin
    if (lk.arst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // The mode outlives frames, so only the device reset or the stop command clears it.
  always_ff @(negedge lk.sclk or posedge lk.mode_rst)
  begin
    if (lk.mode_rst)
      cont_reg <= 1'b0;
    else
      cont_reg <= cont_next;
  end

  //////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    t_next = t_reg;
    rd_tgl_next = rd_tgl_reg;
    // Data out only moves once a read is decoded or while continuous mode is on.
    if (r_reg.reading || cont_reg)
    begin
      t_next.tx = lk.word[5'h1f - t_reg.idx];
      t_next.shifted = 1'b1;
      // Wrapping the index repeats the same bytes for a redundant read.
      if (t_reg.idx == (lk.len4 ? WORD4_LAST : WORD3_LAST))
        t_next.idx = 5'h00;
      else
        t_next.idx = t_reg.idx + 5'h01;
      if (!t_reg.shifted)
        rd_tgl_next = ~rd_tgl_reg;
    end
  end

  always_ff @(posedge lk.sclk or posedge lk.arst)
  begin
    if (lk.arst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  always_ff @(posedge lk.sclk or posedge lk.mode_rst)
  begin
    if (lk.mode_rst)
      rd_tgl_reg <= 1'b0;
    else
      rd_tgl_reg <= rd_tgl_next;
  end

  assign lk.tx = t_reg.tx;
  assign lk.shifted = t_reg.shifted;
  assign lk.cont = cont_reg;
  assign lk.rd_tgl = rd_tgl_reg;

endmodule // adcsp_link

// ==== core/adcsp_readout_port.sv ====
// Top of the converter serial readout port, on the converter clock.
// Assumes conversion results, update and start strobes from the datapath
// arrive on clk; chip select, serial clock and data in come from pins.
`timescale 1ns/1ps

module adcsp_readout_port
  import adcsp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic conversion_ready_n,
  output logic ready_status_n,
  output logic continuous_read_mode,
  input wire logic conv_valid,
  input wire logic [24:0] conv_raw,
  input wire logic conv_oor,
  input wire logic conv_update,
  input wire logic conv_start,
  input wire logic pulse_mode,
  input wire logic checksum_enable,
  input wire logic range_flag_enable,
  input wire logic timeout_enable
);

  adcsp_core_t s_reg;
  adcsp_core_t s_next;
  logic rd_event;
  logic to_idle;
  logic to_hit;
  logic [23:0] sat_code;

  adcsp_link_if lk ();

  adcsp_link u_link
  (
    .lk(lk)
  );

  //////////////////////////////////////////////////////////////////////////

  // Clamps the wide datapath value to the 24-bit code range.
  function automatic logic [23:0] saturate(input logic [24:0] raw);
    logic [23:0] code;
    code = raw[23:0];
    if (!raw[24] && raw[23])
      code = SAT_POS;
    else if (raw[24] && !raw[23])
      code = SAT_NEG;
    return code;
  endfunction

  // Packs the result with the optional flag and the optional checksum.
  function automatic logic [31:0] pack_word(
    input logic [23:0] code,
    input logic oor,
    input logic chk_en,
    input logic flag_en
  );
    logic [23:0] d;
    logic [7:0] sum;
    d = code;
    if (flag_en && !chk_en)
      d[0] = oor;
    sum = d[23:16] + d[15:8] + d[7:0] + CHK_OFFSET;
    if (flag_en)
      sum[7] = oor;
    if (!chk_en)
      sum = 8'h00;
    return {d, sum};
  endfunction

  //////////////////////////////////////////////////////////////////////////

  assign sat_code = saturate(conv_raw);
  assign rd_event = s_reg.rd_s[1] ^ s_reg.rd_d;
  assign to_idle = timeout_enable && !s_reg.sclk_s[1] && !s_reg.cs_s[1];
  assign to_hit = to_idle && s_reg.to_cnt == 17'(TIMEOUT_CYCLES - 1);

  always_comb
  begin
    s_next = s_reg;
    s_next.cs_s = {s_reg.cs_s[0], cs_n};
    s_next.sclk_s = {s_reg.sclk_s[0], sclk};
    s_next.tx_s = {s_reg.tx_s[0], lk.tx};
    s_next.shift_s = {s_reg.shift_s[0], lk.shifted};
    s_next.cont_s = {s_reg.cont_s[0], lk.cont};
    s_next.rd_s = {s_reg.rd_s[0], lk.rd_tgl};
    s_next.rd_d = s_reg.rd_s[1];
    s_next.cont = s_reg.cont_s[1];
    s_next.mode_rst = 1'b0;

    // Idle clock timeout on the converter clock.
    s_next.link_rst = to_hit;
    if (!to_idle || to_hit)
      s_next.to_cnt = 17'h00000;
    else
      s_next.to_cnt = s_reg.to_cnt + 17'h00001;

    // A fresh result wins over any clear in the same cycle.
    if (conv_valid)
    begin
      s_next.ready_n = 1'b0;
      s_next.word = pack_word(sat_code, conv_oor, checksum_enable,
        range_flag_enable);
      s_next.len4 = checksum_enable;
    end
    else if (!pulse_mode && conv_update && !s_reg.ready_n)
      s_next.ready_n = 1'b1;
    else if (!pulse_mode && rd_event)
      s_next.ready_n = 1'b1;
    else if (pulse_mode && conv_start)
      s_next.ready_n = 1'b1;

    // The status bit only tracks ready once continuous mode is left.
    s_next.status_n = s_reg.cont ? 1'b1 : s_reg.ready_n;

    if (s_reg.cs_s[1])
    begin
      s_next.sdo_oe_n = 1'b1;
      s_next.sdo = 1'b0;
    end
    else
    begin
      s_next.sdo_oe_n = 1'b0;
      if (s_reg.cont && !s_reg.shift_s[1])
        s_next.sdo = s_reg.ready_n;
      else
        s_next.sdo = s_reg.tx_s[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.cs_s <= 2'h3;
      s_reg.ready_n <= READY_RST;
      s_reg.mode_rst <= 1'b1;
      s_reg.sdo_oe_n <= 1'b1;
      s_reg.status_n <= READY_RST;
    end
    else
      s_reg <= s_next;
  end

  //////////////////////////////////////////////////////////////////////////

  // The raw pin level resets the link at once; timeout comes from a flop.
  assign lk.arst = cs_n || s_reg.link_rst || s_reg.mode_rst;
  assign lk.mode_rst = s_reg.mode_rst;
  assign lk.sclk = sclk;
  assign lk.sdi = sdi;
  assign lk.word = s_reg.word;
  assign lk.len4 = s_reg.len4;

  assign sdo = s_reg.sdo;
  assign sdo_oe_n = s_reg.sdo_oe_n;
  assign conversion_ready_n = s_reg.ready_n;
  assign ready_status_n = s_reg.status_n;
  assign continuous_read_mode = s_reg.cont;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_new_result;
    conv_valid;
  endsequence

  sequence s_long_idle;
    to_idle && s_reg.to_cnt == 17'(TIMEOUT_CYCLES - 1);
  endsequence

  property p_ready_after_reset;
    disable iff (1'b0) rst |=> conversion_ready_n;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset)
    else $error("ready not inactive after reset");

  property p_float_deselected;
    s_reg.cs_s[1] |=> sdo_oe_n && !sdo;
  endproperty
  a_float_deselected: assert property (p_float_deselected)
    else $error("data out driven while deselected");

  property p_timeout_fires;
    s_long_idle |=> s_reg.link_rst ##1 !s_reg.link_rst;
  endproperty
  a_timeout_fires: assert property (p_timeout_fires)
    else $error("idle clock timeout missing");

  property p_no_early_timeout;
    s_reg.link_rst |-> $past(timeout_enable) && $past(s_reg.to_cnt) ==
      17'(TIMEOUT_CYCLES - 1);
  endproperty
  a_no_early_timeout: assert property (p_no_early_timeout)
    else $error("timeout before full idle count");

  property p_gated_read_clears;
    !pulse_mode && rd_event && !conv_valid |=> conversion_ready_n;
  endproperty
  a_gated_read_clears: assert property (p_gated_read_clears)
    else $error("ready not cleared by read");

  property p_unread_pulse;
    !pulse_mode && conv_update && !conversion_ready_n && !conv_valid
      |=> conversion_ready_n;
  endproperty
  a_unread_pulse: assert property (p_unread_pulse)
    else $error("ready did not pulse before update");

  property p_pulse_hold;
    pulse_mode && !conversion_ready_n && !conv_start |=>
      !conversion_ready_n;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("ready left low state without start");

  property p_saturate_pos;
    s_new_result ##0 (!conv_raw[24] && conv_raw[23]) |=>
      s_reg.word[31:8] == SAT_POS || s_reg.word[31:9] == SAT_POS[23:1];
  endproperty
  a_saturate_pos: assert property (p_saturate_pos)
    else $error("positive overrange not clamped");

  property p_checksum;
    s_new_result ##0 (checksum_enable && !range_flag_enable) |=>
      s_reg.word[7:0] == 8'(s_reg.word[31:24] + s_reg.word[23:16] +
      s_reg.word[15:8] + CHK_OFFSET) && s_reg.len4;
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum byte wrong");

  property p_flag_lsb;
    s_new_result ##0 (range_flag_enable && !checksum_enable) |=>
      s_reg.word[8] == $past(conv_oor) && s_reg.word[7:0] == 8'h00;
  endproperty
  a_flag_lsb: assert property (p_flag_lsb)
    else $error("range flag not in result bit zero");

  property p_mirror;
    !s_reg.cs_s[1] && s_reg.cont && !s_reg.shift_s[1] |=>
      sdo == $past(conversion_ready_n);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("data out does not mirror ready");

endmodule // adcsp_readout_port

// ==== testbench/adcsp_host.sv ====
// Host-side serial master model for the converter readout port.
// Assumes the bench resolves the data-out wire and feeds it back here.
`timescale 1ns/1ps

module adcsp_host
(
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_pin
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // The wait after a chip select change covers the port's three-cycle sync.
  task automatic set_cs(input logic on);
    cs_n = !on;
    #30;
  endtask

  // Bits go out MSB first and the clock rests low between bits.
  task automatic send_bits(input int n, input logic [7:0] v);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = v[i];
      #3 sclk = 1'b1;
      #6 sclk = 1'b0;
      #3;
    end
    sdi = 1'b0;
  endtask

  // The low phase is stretched because data out lags the rising edge.
  task automatic read_bits(input int n, output logic [31:0] v);
    v = '0;
    repeat (n)
    begin
      sclk = 1'b1;
      #6 sclk = 1'b0;
      #14;
      v = {v[30:0], sdo_pin};
    end
  endtask
endmodule // adcsp_host

// ==== testbench/adcsp_readout_port_test.sv ====
// Self-checking bench of the converter serial readout port.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] %0t %s", $time, msg); \
    end \
  end

module adcsp_readout_port_test;
  import adcsp_pkg::*;
  typedef struct packed {
    logic [24:0] raw;
    logic oor;
    logic chk;
    logic flg;
  } adcsp_row_t;

  logic clk = 1'b0;
  logic rst;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic ready_n;
  logic stat_n;
  logic cont;
  logic conv_valid;
  logic [24:0] conv_raw;
  logic conv_oor;
  logic conv_update;
  logic conv_start;
  logic pulse_mode;
  logic chk_en;
  logic flg_en;
  logic to_en;
  logic sdo_q = 1'b0;
  logic sdo_pin;
  logic [31:0] got;
  logic [31:0] e;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  adcsp_row_t rows [5] = '{
    '{25'h0123456, 1'b0, 1'b0, 1'b0},
    '{25'h0800000, 1'b0, 1'b1, 1'b0},
    '{25'h1123456, 1'b1, 1'b0, 1'b1},
    '{25'h1fedcba, 1'b1, 1'b1, 1'b1},
    '{25'h07fffff, 1'b0, 1'b0, 1'b1}};

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // A floating data-out line shows the inverse of its last driven level.
  always @(posedge clk)
    if (!sdo_oe_n)
      sdo_q <= sdo;
  assign sdo_pin = sdo_oe_n ? ~sdo_q : sdo;

  adcsp_host u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_pin(sdo_pin));

  adcsp_readout_port #(.TIMEOUT_CYCLES(64)) u_dut (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .conversion_ready_n(ready_n),
    .ready_status_n(stat_n), .continuous_read_mode(cont),
    .conv_valid(conv_valid), .conv_raw(conv_raw), .conv_oor(conv_oor),
    .conv_update(conv_update), .conv_start(conv_start),
    .pulse_mode(pulse_mode), .checksum_enable(chk_en),
    .range_flag_enable(flg_en), .timeout_enable(to_en));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_word(input adcsp_row_t r);
    logic [23:0] c;
    logic [7:0] s;
    c = r.raw[23:0];
    if (!r.raw[24] && r.raw[23]) c = SAT_POS;
    if (r.raw[24] && !r.raw[23]) c = SAT_NEG;
    if (r.flg && !r.chk) c[0] = r.oor;
    s = c[23:16] + c[15:8] + c[7:0] + 8'h9b;
    if (r.flg) s[7] = r.oor;
    return {c, s};
  endfunction

  task automatic summarize();
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Enables settle one cycle before the strobe that captures the word.
  task automatic convert(input adcsp_row_t r);
    @(posedge clk);
    chk_en <= r.chk;
    flg_en <= r.flg;
    @(posedge clk);
    conv_raw <= r.raw;
    conv_oor <= r.oor;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic strobe(input logic start);
    @(posedge clk);
    if (start) conv_start <= 1'b1;
    else conv_update <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    conv_update <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Reads follow the strobe at once, far ahead of the next result.
  task automatic read_cmd(input int n);
    u_host.set_cs(1'b1);
    u_host.send_bits(8, CMD_READ_DATA);
    u_host.read_bits(n, got);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst <= 1'b1;
    conv_valid <= 1'b0;
    conv_raw <= 25'h0000000;
    conv_oor <= 1'b0;
    conv_update <= 1'b0;
    conv_start <= 1'b0;
    pulse_mode <= 1'b0;
    chk_en <= 1'b0;
    flg_en <= 1'b0;
    to_en <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(ready_n, 1'b1, "ready after reset")
    `CHK(sdo_oe_n, 1'b1, "oe after reset")
    `CHK(cont, 1'b0, "mode after reset")
    `CHK(stat_n, 1'b1, "bit after reset")
    foreach (rows[i])
    begin
      e = exp_word(rows[i]);
      convert(rows[i]);
      `CHK(ready_n, 1'b0, "ready pin low")
      `CHK(stat_n, 1'b0, "ready bit low")
      read_cmd(rows[i].chk ? 32 : 24);
      `CHK(got, rows[i].chk ? e : {8'h00, e[31:8]}, "word")
      `CHK(ready_n, 1'b1, "read clears ready")
      u_host.read_bits(24, got);
      `CHK(got[23:0], e[31:8], "repeat")
      u_host.set_cs(1'b0);
      `CHK(sdo_oe_n, 1'b1, "line floats")
    end
    // Pulsed mode keeps ready through a read until the next start.
    pulse_mode <= 1'b1;
    convert(rows[0]);
    read_cmd(24);
    u_host.set_cs(1'b0);
    `CHK(ready_n, 1'b0, "pulsed ready kept")
    strobe(1'b1);
    `CHK(ready_n, 1'b1, "start releases")
    pulse_mode <= 1'b0;
    convert(rows[0]);
    `CHK(ready_n, 1'b0, "gated ready low")
    strobe(1'b0);
    `CHK(ready_n, 1'b1, "unread update pulse")
    // Continuous mode: data out mirrors ready, then the stop command leaves.
    u_host.set_cs(1'b1);
    u_host.send_bits(8, CMD_CONT_READ);
    u_host.set_cs(1'b0);
    `CHK(cont, 1'b1, "continuous set")
    `CHK(stat_n, 1'b1, "bit idle in continuous")
    u_host.set_cs(1'b1);
    `CHK(sdo_oe_n, 1'b0, "driven while selected")
    `CHK(sdo_pin, 1'b1, "mirror idle")
    convert(rows[1]);
    `CHK(sdo_pin, 1'b0, "mirror ready")
    `CHK(stat_n, 1'b1, "bit held in continuous")
    u_host.read_bits(32, got);
    `CHK(got, exp_word(rows[1]), "continuous word")
    u_host.send_bits(8, CMD_STOP_READ);
    u_host.set_cs(1'b0);
    `CHK(cont, 1'b0, "continuous left")
    // A half byte then an idle clock: the timeout must realign the bytes.
    to_en <= 1'b1;
    u_host.set_cs(1'b1);
    u_host.send_bits(4, 8'h0f);
    #400;
    // The odd twin of the read opcode is taken as a read as well.
    u_host.send_bits(8, CMD_READ_DATA | 8'h01);
    u_host.read_bits(32, got);
    `CHK(got, exp_word(rows[1]), "after timeout")
    u_host.set_cs(1'b0);
    // A reset in mid-run must drop a pending result back to inactive.
    convert(rows[0]);
    `CHK(ready_n, 1'b0, "ready before reset")
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(ready_n, 1'b1, "ready after mid reset")
    `CHK(stat_n, 1'b1, "bit after mid reset")
    `CHK(sdo_oe_n, 1'b1, "oe after mid reset")
    summarize();
  end
endmodule // adcsp_readout_port_test
